// File: hw/cocr_pkg.sv
// Shared constants for the clock output configuration register bank
package cocr_pkg;

    // Replication counts
    localparam int NCLK = 10;
    localparam int NREF = 8;

    // Serial port frame: 1 command bit, 7 address bits, 8 data bits
    localparam int ADDR_W      = 7;
    localparam int DATA_W      = 8;
    localparam int HDR_BITS    = 8;
    localparam int FRAME_BITS  = 16;
    localparam int CNT_W       = 5;
    localparam int CMD_BIT_HDR = 7;

    // Register offsets, element 0 is output A0
    localparam logic [NREF-1:0][ADDR_W-1:0] REF_DLY_ADDR = {
        7'h58, 7'h49, 7'h48, 7'h39, 7'h38, 7'h2a, 7'h29, 7'h28};
    localparam logic [NREF-1:0][ADDR_W-1:0] REF_DRV_ADDR = {
        7'h5c, 7'h4d, 7'h4c, 7'h3d, 7'h3c, 7'h2e, 7'h2d, 7'h2c};
    localparam logic [NCLK-1:0][ADDR_W-1:0] CLK_DRV_ADDR = {
        7'h65, 7'h64, 7'h54, 7'h45, 7'h44, 7'h35, 7'h34,
        7'h26, 7'h25, 7'h24};
    localparam logic [ADDR_W-1:0] CLK_EN_HI_ADDR = 7'h74;
    localparam logic [ADDR_W-1:0] CLK_EN_LO_ADDR = 7'h75;
    localparam logic [ADDR_W-1:0] REF_EN_ADDR    = 7'h76;

    // Delay/source register field positions
    localparam int FINE_LO_HI  = 6;
    localparam int FINE_LO_LO  = 5;
    localparam int SRC_BIT     = 4;
    localparam int COARSE_HI   = 3;
    localparam int COARSE_LO   = 1;
    localparam int FINE_HI_BIT = 0;

    // Driver register field positions
    localparam int PD_BIT    = 7;
    localparam int BIAS_BIT  = 5;
    localparam int STYLE_BIT = 4;
    localparam int SWING_HI  = 3;
    localparam int SWING_LO  = 2;

    // Low enable register: channel E outputs
    localparam int E0_EN_BIT = 0;
    localparam int E1_EN_BIT = 1;
    localparam int E0_IDX    = 8;
    localparam int E1_IDX    = 9;

    // Reset values of fields that are not zero
    localparam logic REF_SRC_RST = 1'h1;

    // Analog step sizes
    localparam int MV_W = 10;
    localparam int PS_W = 11;
    localparam logic [MV_W-1:0] SWING_STEP_MV  = 10'h0fa;
    localparam logic [PS_W-1:0] COARSE_STEP_PS = 11'h0cb;
    localparam logic [7:0][7:0] FINE_PS = {
        8'ha0, 8'h87, 8'h6e, 8'h55, 8'h4b, 8'h32, 8'h19, 8'h00};

endpackage : cocr_pkg

// File: hw/cocr_cfg_if.sv
// Write and read strobes from the serial port to the register bank
`timescale 1ns/100ps
interface cocr_cfg_if;
    logic                           wr_stb;
    logic                           rd_stb;
    logic [cocr_pkg::ADDR_W-1:0]    addr;
    logic [cocr_pkg::DATA_W-1:0]    wdata;
    logic [cocr_pkg::DATA_W-1:0]    rdata;

    modport regs (input wr_stb, input rd_stb, input addr, input wdata,
                  output rdata);
    modport port (output wr_stb, output rd_stb, output addr, output wdata,
                  input rdata);
endinterface : cocr_cfg_if

// File: hw/cocr_spi_port.sv
// Three-wire serial configuration port, oversampled by the core clock
`timescale 1ns/100ps
module cocr_spi_port (
    input  wire logic   core_clk_in,
    input  wire logic   rst_b_in,
    input  wire logic   spi_sclk_in,
    input  wire logic   spi_cs_b_in,
    input  wire logic   spi_sdio_in,
    output logic        spi_sdio_out,
    output logic        spi_sdio_oe_out,
    cocr_cfg_if.port    cfg
);

    typedef struct packed {
        logic [2:0]                         sclk_s;
        logic [1:0]                         cs_s;
        logic [1:0]                         sdi_s;
        logic [cocr_pkg::FRAME_BITS-1:0]    sh;
        logic [cocr_pkg::CNT_W-1:0]         cnt;
        logic                               rd;
        logic                               load;
        logic [cocr_pkg::DATA_W-1:0]        so;
        logic                               sdo;
        logic                               oe;
        logic                               wr_stb;
        logic                               rd_stb;
    } cocr_spi_state_t;

    cocr_spi_state_t s_r;
    cocr_spi_state_t s_nxt;

    logic rise;
    logic fall;

    // Edges come from the second and third stages, never the first
    assign rise = s_r.sclk_s[1] & ~s_r.sclk_s[2];
    assign fall = ~s_r.sclk_s[1] & s_r.sclk_s[2];

    // Frame decode and shifting
    always_comb begin
        s_nxt        = s_r;
        s_nxt.wr_stb = 1'b0;
        s_nxt.rd_stb = 1'b0;
        s_nxt.load   = s_r.rd_stb;
        s_nxt.sclk_s = {s_r.sclk_s[1:0], spi_sclk_in};
        s_nxt.cs_s   = {s_r.cs_s[0], spi_cs_b_in};
        s_nxt.sdi_s  = {s_r.sdi_s[0], spi_sdio_in};
        if (s_r.load) begin
            s_nxt.so = cfg.rdata;
        end
        if (s_r.cs_s[1]) begin
            // Deselect aborts any partial frame
            s_nxt.cnt = '0;
            s_nxt.rd  = 1'b0;
            s_nxt.oe  = 1'b0;
        end else begin
            if (rise && s_r.cnt < cocr_pkg::CNT_W'(cocr_pkg::FRAME_BITS)) begin
                s_nxt.sh  = {s_r.sh[cocr_pkg::FRAME_BITS-2:0], s_r.sdi_s[1]};
                s_nxt.cnt = s_r.cnt + 5'h01;
                if (s_r.cnt == cocr_pkg::CNT_W'(cocr_pkg::HDR_BITS - 1)
                    && s_nxt.sh[cocr_pkg::CMD_BIT_HDR]) begin
                    s_nxt.rd     = 1'b1;
                    s_nxt.rd_stb = 1'b1;
                end
                if (s_r.cnt == cocr_pkg::CNT_W'(cocr_pkg::FRAME_BITS - 1)
                    && !s_r.rd) begin
                    s_nxt.wr_stb = 1'b1;
                end
            end
            // Read data leaves on falling edges so the master samples rising
            if (fall && s_r.rd
                && s_r.cnt >= cocr_pkg::CNT_W'(cocr_pkg::HDR_BITS)
                && s_r.cnt < cocr_pkg::CNT_W'(cocr_pkg::FRAME_BITS)) begin
                s_nxt.sdo = s_r.so[cocr_pkg::DATA_W-1];
                s_nxt.so  = {s_r.so[cocr_pkg::DATA_W-2:0], 1'b0};
                s_nxt.oe  = 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            s_r <= '{cs_s: 2'h3, default: '0};
        end else begin
            s_r <= s_nxt;
        end
    end

    // Address sits in the low byte during a read header
    assign cfg.addr = s_r.rd ? s_r.sh[cocr_pkg::ADDR_W-1:0]
                             : s_r.sh[cocr_pkg::DATA_W+cocr_pkg::ADDR_W-1:
                                      cocr_pkg::DATA_W];
    assign cfg.wdata       = s_r.sh[cocr_pkg::DATA_W-1:0];
    assign cfg.wr_stb      = s_r.wr_stb;
    assign cfg.rd_stb      = s_r.rd_stb;
    assign spi_sdio_out    = s_r.sdo;
    assign spi_sdio_oe_out = s_r.oe;

endmodule : cocr_spi_port

// File: hw/cocr_regs.sv
// Clock and reference output driver configuration register bank
//
// Summary of operation
// - Each clock output has a 2-bit swing, 250 to 1000 mV, default 00.
// - Each clock output format bit: 0 low-voltage differential, 1 emitter.
// - Clock output enable, default 0; disabled output held low.
// - Reference settings replicated for eight outputs A0..D, none on E.
// - Delay register: fine low 6:5, source 4, coarse 3:1, fine high 0.
// - Driver register: powerdown 7, bias 5, format 4, swing 3:2.
// - Register ref_output_enables holds reference enables, bit 7 A0 down to bit 0 D.
// - Source select default 1; 0 channel clock, 1 system reference.
// - Coarse delay is code times 203 ps, default 000.
// - Fine delay adds 0,25,50,75,85,110,135,160 ps on top of coarse.
`timescale 1ns/100ps
module cocr_regs (
    input  wire logic                   core_clk_in,
    input  wire logic                   rst_b_in,
    // Serial configuration pins
    input  wire logic                   spi_sclk_in,
    input  wire logic                   spi_cs_b_in,
    input  wire logic                   spi_sdio_in,
    output logic                        spi_sdio_out,
    output logic                        spi_sdio_oe_out,
    // Divided clocks and reference sources
    input  wire logic [9:0]             clk_div_in,
    input  wire logic [7:0]             ref_chan_clk_in,
    input  wire logic                   sysref_in,
    // Clock output settings
    output logic [9:0]                  clock_output_out,
    output logic [9:0][1:0]             clk_swing_out,
    output logic [9:0][9:0]             clk_swing_mv_out,
    output logic [9:0]                  clk_lvpecl_out,
    output logic [9:0]                  clk_powerdown_out,
    output logic [9:0]                  clk_on_out,
    // Reference output settings
    output logic [7:0]                  reference_output_out,
    output logic [7:0]                  ref_source_sel_out,
    output logic [7:0][2:0]             ref_coarse_out,
    output logic [7:0][2:0]             ref_fine_out,
    output logic [7:0][10:0]            ref_delay_ps_out,
    output logic [7:0]                  ref_bias_on_out,
    output logic [7:0]                  ref_powerdown_out,
    output logic [7:0]                  ref_lvpecl_out,
    output logic [7:0][1:0]             ref_swing_out,
    output logic [7:0][9:0]             ref_swing_mv_out,
    output logic [7:0]                  ref_on_out
);

    localparam int NCLK = cocr_pkg::NCLK;
    localparam int NREF = cocr_pkg::NREF;
    localparam int MV_W = cocr_pkg::MV_W;
    localparam int PS_W = cocr_pkg::PS_W;

    typedef struct packed {
        // Clock outputs
        logic [NCLK-1:0][1:0]       clk_swing;
        logic [NCLK-1:0]            clk_pecl;
        logic [NCLK-1:0]            clk_pd;
        logic [NCLK-1:0]            clk_on;
        logic [NCLK-1:0][MV_W-1:0]  clk_mv;
        logic [NCLK-1:0]            clk_q;
        // Reference outputs
        logic [NREF-1:0][2:0]       ref_fine;
        logic [NREF-1:0]            ref_src;
        logic [NREF-1:0][2:0]       ref_crs;
        logic [NREF-1:0]            ref_pd;
        logic [NREF-1:0]            ref_bias;
        logic [NREF-1:0]            ref_pecl;
        logic [NREF-1:0][1:0]       ref_swing;
        logic [NREF-1:0]            ref_on;
        logic [NREF-1:0][PS_W-1:0]  ref_ps;
        logic [NREF-1:0][MV_W-1:0]  ref_mv;
        logic [NREF-1:0]            ref_q;
        // Read return byte
        logic [cocr_pkg::DATA_W-1:0] rdata;
    } cocr_reg_state_t;

    // Source select resets high, millivolt values to one 250 mV step, everything else low
    localparam cocr_reg_state_t REG_RST = '{
        ref_src: {NREF{cocr_pkg::REF_SRC_RST}},
        ref_mv:  {NREF{cocr_pkg::SWING_STEP_MV}},
        clk_mv:  {NCLK{cocr_pkg::SWING_STEP_MV}},
        default: '0};

    cocr_reg_state_t s_r;
    cocr_reg_state_t s_nxt;

    cocr_cfg_if cfg ();

    // Serial port front end
    cocr_spi_port u_spi (
        .core_clk_in     (core_clk_in),
        .rst_b_in        (rst_b_in),
        .spi_sclk_in     (spi_sclk_in),
        .spi_cs_b_in     (spi_cs_b_in),
        .spi_sdio_in     (spi_sdio_in),
        .spi_sdio_out    (spi_sdio_out),
        .spi_sdio_oe_out (spi_sdio_oe_out),
        .cfg             (cfg.port)
    );

    // Swing code to millivolts, same for both formats
    function automatic logic [MV_W-1:0] swing_mv(input logic [1:0] code);
        swing_mv = (MV_W'(code) + 10'h001) * cocr_pkg::SWING_STEP_MV;
    endfunction : swing_mv

    // Total reference delay: coarse steps plus fine table
    function automatic logic [PS_W-1:0] dly_ps(input logic [2:0] crs,
                                               input logic [2:0] fine);
        dly_ps = PS_W'(crs) * cocr_pkg::COARSE_STEP_PS
               + PS_W'(cocr_pkg::FINE_PS[fine]);
    endfunction : dly_ps

    // Pack a delay/source register, reserved bit 7 reads zero
    function automatic logic [7:0] pack_dly(input logic [2:0] fine,
                                            input logic       src,
                                            input logic [2:0] crs);
        logic [7:0] r;
        r = 8'h00;
        r[cocr_pkg::FINE_LO_HI:cocr_pkg::FINE_LO_LO] = fine[1:0];
        r[cocr_pkg::SRC_BIT] = src;
        r[cocr_pkg::COARSE_HI:cocr_pkg::COARSE_LO] = crs;
        r[cocr_pkg::FINE_HI_BIT] = fine[2];
        pack_dly = r;
    endfunction : pack_dly

    // Pack a driver register; bias is zero for clock outputs
    function automatic logic [7:0] pack_drv(input logic       pd,
                                            input logic       bias,
                                            input logic       pecl,
                                            input logic [1:0] swing);
        logic [7:0] r;
        r = 8'h00;
        r[cocr_pkg::PD_BIT] = pd;
        r[cocr_pkg::BIAS_BIT] = bias;
        r[cocr_pkg::STYLE_BIT] = pecl;
        r[cocr_pkg::SWING_HI:cocr_pkg::SWING_LO] = swing;
        pack_drv = r;
    endfunction : pack_drv

    // Read multiplexer; unmapped offsets return zero
    function automatic logic [7:0] rd_byte(input cocr_reg_state_t s,
                                           input logic [6:0]      a);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < NREF; i++) begin
            if (a == cocr_pkg::REF_DLY_ADDR[i]) begin
                r = pack_dly(s.ref_fine[i], s.ref_src[i], s.ref_crs[i]);
            end
            if (a == cocr_pkg::REF_DRV_ADDR[i]) begin
                r = pack_drv(s.ref_pd[i], s.ref_bias[i], s.ref_pecl[i],
                             s.ref_swing[i]);
            end
        end
        for (int i = 0; i < NCLK; i++) begin
            if (a == cocr_pkg::CLK_DRV_ADDR[i]) begin
                r = pack_drv(s.clk_pd[i], 1'b0, s.clk_pecl[i],
                             s.clk_swing[i]);
            end
        end
        // Reference and high clock enable registers list output A0 in the top bit; the low one holds E0 and E1 in bits 0 and 1
        if (a == cocr_pkg::REF_EN_ADDR) begin
            for (int i = 0; i < NREF; i++) begin
                r[NREF-1-i] = s.ref_on[i];
            end
        end
        if (a == cocr_pkg::CLK_EN_HI_ADDR) begin
            for (int i = 0; i < NREF; i++) begin
                r[NREF-1-i] = s.clk_on[i];
            end
        end
        if (a == cocr_pkg::CLK_EN_LO_ADDR) begin
            r[cocr_pkg::E0_EN_BIT] = s.clk_on[cocr_pkg::E0_IDX];
            r[cocr_pkg::E1_EN_BIT] = s.clk_on[cocr_pkg::E1_IDX];
        end
        rd_byte = r;
    endfunction : rd_byte

    // Register writes, read capture and derived outputs
    always_comb begin
        s_nxt = s_r;
        if (cfg.wr_stb) begin
            // Reference registers, eight copies
            for (int i = 0; i < NREF; i++) begin
                if (cfg.addr == cocr_pkg::REF_DLY_ADDR[i]) begin
                    s_nxt.ref_fine[i] = {
                        cfg.wdata[cocr_pkg::FINE_HI_BIT],
                        cfg.wdata[cocr_pkg::FINE_LO_HI:
                                  cocr_pkg::FINE_LO_LO]};
                    s_nxt.ref_src[i] = cfg.wdata[cocr_pkg::SRC_BIT];
                    s_nxt.ref_crs[i] =
                        cfg.wdata[cocr_pkg::COARSE_HI:cocr_pkg::COARSE_LO];
                end
                if (cfg.addr == cocr_pkg::REF_DRV_ADDR[i]) begin
                    s_nxt.ref_pd[i]   = cfg.wdata[cocr_pkg::PD_BIT];
                    s_nxt.ref_bias[i] = cfg.wdata[cocr_pkg::BIAS_BIT];
                    s_nxt.ref_pecl[i] = cfg.wdata[cocr_pkg::STYLE_BIT];
                    s_nxt.ref_swing[i] =
                        cfg.wdata[cocr_pkg::SWING_HI:cocr_pkg::SWING_LO];
                end
            end
            // Clock driver registers, ten copies
            for (int i = 0; i < NCLK; i++) begin
                if (cfg.addr == cocr_pkg::CLK_DRV_ADDR[i]) begin
                    s_nxt.clk_pd[i]   = cfg.wdata[cocr_pkg::PD_BIT];
                    s_nxt.clk_pecl[i] =
                        cfg.wdata[cocr_pkg::STYLE_BIT];
                    s_nxt.clk_swing[i] =
                        cfg.wdata[cocr_pkg::SWING_HI:
                                  cocr_pkg::SWING_LO];
                end
            end
            // Packed enable registers
            if (cfg.addr == cocr_pkg::REF_EN_ADDR) begin
                for (int i = 0; i < NREF; i++) begin
                    s_nxt.ref_on[i] = cfg.wdata[NREF-1-i];
                end
            end
            if (cfg.addr == cocr_pkg::CLK_EN_HI_ADDR) begin
                for (int i = 0; i < NREF; i++) begin
                    s_nxt.clk_on[i] = cfg.wdata[NREF-1-i];
                end
            end
            if (cfg.addr == cocr_pkg::CLK_EN_LO_ADDR) begin
                s_nxt.clk_on[cocr_pkg::E0_IDX] =
                    cfg.wdata[cocr_pkg::E0_EN_BIT];
                s_nxt.clk_on[cocr_pkg::E1_IDX] =
                    cfg.wdata[cocr_pkg::E1_EN_BIT];
            end
        end
        // Read data sampled from current contents
        if (cfg.rd_stb) begin
            s_nxt.rdata = rd_byte(s_r, cfg.addr);
        end
        // Millivolt and delay values follow the stored fields with no extra lag, gated outputs one clock later
        for (int i = 0; i < NCLK; i++) begin
            s_nxt.clk_mv[i] = swing_mv(s_nxt.clk_swing[i]);
            // Disabled output parks low rather than floating
            s_nxt.clk_q[i]  = clk_div_in[i] & s_r.clk_on[i];
        end
        for (int i = 0; i < NREF; i++) begin
            s_nxt.ref_mv[i] = swing_mv(s_nxt.ref_swing[i]);
            s_nxt.ref_ps[i] = dly_ps(s_nxt.ref_crs[i], s_nxt.ref_fine[i]);
            s_nxt.ref_q[i]  = s_r.ref_on[i]
                            & (s_r.ref_src[i] ? sysref_in
                                              : ref_chan_clk_in[i]);
        end
    end

    // State register
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            s_r <= REG_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign cfg.rdata = s_r.rdata;

    // Clock output settings
    assign clock_output_out  = s_r.clk_q;
    assign clk_swing_out     = s_r.clk_swing;
    assign clk_swing_mv_out  = s_r.clk_mv;
    assign clk_lvpecl_out    = s_r.clk_pecl;
    assign clk_powerdown_out = s_r.clk_pd;
    assign clk_on_out        = s_r.clk_on;

    // Reference output settings
    assign reference_output_out = s_r.ref_q;
    assign ref_source_sel_out   = s_r.ref_src;
    assign ref_coarse_out       = s_r.ref_crs;
    assign ref_fine_out         = s_r.ref_fine;
    assign ref_delay_ps_out     = s_r.ref_ps;
    assign ref_bias_on_out      = s_r.ref_bias;
    assign ref_powerdown_out    = s_r.ref_pd;
    assign ref_lvpecl_out       = s_r.ref_pecl;
    assign ref_swing_out        = s_r.ref_swing;
    assign ref_swing_mv_out     = s_r.ref_mv;
    assign ref_on_out           = s_r.ref_on;

endmodule : cocr_regs

// File: tb/cocr_regs_monitor.sv
// Checker of output gating and derived settings of the register bank
`timescale 1ns/100ps
module cocr_regs_monitor (
    input logic             core_clk_in,
    input logic             rst_b_in,
    input logic             spi_cs_b_in,
    input logic             spi_sdio_oe_out,
    input logic [9:0]       clk_div_in,
    input logic [7:0]       ref_chan_clk_in,
    input logic             sysref_in,
    input logic [9:0]       clock_output_out,
    input logic [9:0][1:0]  clk_swing_out,
    input logic [9:0][9:0]  clk_swing_mv_out,
    input logic [9:0]       clk_on_out,
    input logic [7:0]       reference_output_out,
    input logic [7:0]       ref_source_sel_out,
    input logic [7:0][2:0]  ref_coarse_out,
    input logic [7:0][2:0]  ref_fine_out,
    input logic [7:0][10:0] ref_delay_ps_out,
    input logic [7:0][1:0]  ref_swing_out,
    input logic [7:0][9:0]  ref_swing_mv_out,
    input logic [7:0]       ref_on_out
);
    // Own copy of the fine steps, so a wrong design table is caught
    localparam logic [7:0][7:0] FINE_T = {8'ha0, 8'h87, 8'h6e, 8'h55,
        8'h4b, 8'h32, 8'h19, 8'h00};
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_b_in);

    // Outputs follow their source one clock late, low while disabled
    property p_clk_gate;
        clock_output_out == $past(clk_div_in & clk_on_out);
    endproperty
    property p_ref_gate;
        reference_output_out == $past(ref_on_out & (ref_source_sel_out &
            {8{sysref_in}} | ~ref_source_sel_out & ref_chan_clk_in));
    endproperty
    // Driver released soon after the frame ends, never while idle
    property p_oe_drop;
        $rose(spi_cs_b_in) |-> ##[1:6] !spi_sdio_oe_out;
    endproperty
    property p_oe_idle;
        spi_cs_b_in [*6] |-> !spi_sdio_oe_out;
    endproperty
    // No frame, no change of settings
    property p_quiet;
        spi_cs_b_in [*8] |=> $stable(ref_source_sel_out) &&
            $stable(clk_on_out) && $stable(ref_swing_out);
    endproperty
    property p_rst_val;
        $rose(rst_b_in) |-> ref_source_sel_out == 8'hff &&
            clk_on_out == 10'h0 && ref_coarse_out == 24'h0;
    endproperty
    a_clk_gate: assert property (p_clk_gate)
        else $error("clock output gating wrong");
    a_ref_gate: assert property (p_ref_gate)
        else $error("reference output source wrong");
    a_oe_drop: assert property (p_oe_drop)
        else $error("data driver not released");
    a_oe_idle: assert property (p_oe_idle)
        else $error("data driver on while idle");
    a_quiet: assert property (p_quiet)
        else $error("setting changed without a frame");
    a_rst_val: assert property (p_rst_val)
        else $error("reset value wrong");
    for (genvar i = 0; i < 10; i++) begin : g_clk
        property p_clk_mv;
            clk_swing_mv_out[i] == (10'h1 + clk_swing_out[i]) * 10'h0fa;
        endproperty
        a_clk_mv: assert property (p_clk_mv)
            else $error("clock swing millivolts wrong");
    end
    for (genvar i = 0; i < 8; i++) begin : g_ref
        property p_ref_mv;
            ref_swing_mv_out[i] == (10'h1 + ref_swing_out[i]) * 10'h0fa;
        endproperty
        property p_delay;
            ref_delay_ps_out[i] == ref_coarse_out[i] * 11'h0cb
                + {3'h0, FINE_T[ref_fine_out[i]]};
        endproperty
        a_ref_mv: assert property (p_ref_mv)
            else $error("reference swing millivolts wrong");
        a_delay: assert property (p_delay)
            else $error("reference delay wrong");
    end
    c_read: cover property ($rose(spi_sdio_oe_out));
    c_clk_on: cover property ($rose(|clock_output_out));
    c_chan_src: cover property (ref_source_sel_out != 8'hff);
endmodule : cocr_regs_monitor

bind cocr_regs cocr_regs_monitor u_mon (.core_clk_in, .rst_b_in,
    .spi_cs_b_in, .spi_sdio_oe_out, .clk_div_in, .ref_chan_clk_in,
    .sysref_in, .clock_output_out, .clk_swing_out, .clk_swing_mv_out,
    .clk_on_out, .reference_output_out, .ref_source_sel_out,
    .ref_coarse_out, .ref_fine_out, .ref_delay_ps_out, .ref_swing_out,
    .ref_swing_mv_out, .ref_on_out);

// File: tb/cocr_regs_tb_top.sv
// Self-checking bench for the output configuration register bank
`timescale 1ns/100ps
module cocr_regs_tb_top;
    logic clk = 1'b0, rst_b = 1'b0, sclk = 1'b0, cs_b = 1'b1, sdio = 1'b0;
    logic [9:0] div = 10'h0;
    logic [7:0] chan = 8'h0;
    logic sref = 1'b0, sdo, oe;
    logic [9:0] cko, c_pecl, c_on, c_pd;
    logic [9:0][1:0] c_sw;
    logic [7:0] rfo, r_src, r_bias, r_pd, r_pecl, r_on, cap;
    logic [7:0][2:0] r_crs, r_fin;
    logic [7:0][1:0] r_sw;
    logic [7:0] exp_q[$];
    integer seed = 18156;
    int error_cnt, comparisons, nb;
    // Shared data wire: whoever has the driver on sets the level
    wire sdio_w = (oe === 1'b1) ? sdo : sdio;

    cocr_regs uut (.core_clk_in(clk), .rst_b_in(rst_b), .spi_sclk_in(sclk),
        .spi_cs_b_in(cs_b), .spi_sdio_in(sdio_w), .spi_sdio_out(sdo),
        .spi_sdio_oe_out(oe), .clk_div_in(div), .ref_chan_clk_in(chan),
        .sysref_in(sref), .clock_output_out(cko), .clk_swing_out(c_sw),
        .clk_swing_mv_out(), .clk_lvpecl_out(c_pecl), .clk_powerdown_out(c_pd),
        .clk_on_out(c_on), .reference_output_out(rfo),
        .ref_source_sel_out(r_src), .ref_coarse_out(r_crs),
        .ref_fine_out(r_fin), .ref_delay_ps_out(), .ref_bias_on_out(r_bias),
        .ref_powerdown_out(r_pd), .ref_lvpecl_out(r_pecl),
        .ref_swing_out(r_sw), .ref_swing_mv_out(), .ref_on_out(r_on));

    initial begin
        forever #25 clk = ~clk;
    end
    // Random clock sources keep the output gating busy
    always @(posedge clk) begin
        {div, chan, sref} <= 19'($random(seed));
    end
    // Collect read bits; a full byte is matched with the oldest note
    always @(posedge sclk) begin
        if (oe === 1'b1) begin
            cap = {cap[6:0], sdo};
            nb++;
            if (nb == 8) begin
                nb = 0;
                chk(exp_q.size() ? exp_q.pop_front() : 9'h1ff, cap);
            end
        end
    end

    task automatic chk(input logic [63:0] e, input logic [63:0] g);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : chk
    function automatic logic [7:0] rev8(input logic [7:0] x);
        for (int i = 0; i < 8; i++) rev8[i] = x[7 - i];
    endfunction : rev8
    // One frame, cut short when n is below 16; sclk kept under 2 MHz
    task automatic xfer(input logic rd, input logic [6:0] a,
                        input logic [7:0] d, input int n = 16);
        logic [15:0] f;
        f = {rd, a, d};
        cs_b <= 1'b0;
        for (int k = 15; k > 15 - n; k--) begin
            sdio <= f[k];
            repeat (6) @(posedge clk);
            sclk <= 1'b1;
            repeat (6) @(posedge clk);
            sclk <= 1'b0;
        end
        repeat (6) @(posedge clk);
        cs_b <= 1'b1;
        repeat (8) @(posedge clk);
    endtask : xfer
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        xfer(1'b1, a, 8'h00);
    endtask : rd
    task automatic do_reset();
        rst_b <= 1'b0;
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
    endtask : do_reset
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_of_test

    initial begin
        repeat (100000) @(posedge clk);
        error_cnt++;
        end_of_test();
    end

    initial begin
        logic [7:0] v, w;
        do_reset();
        chk(8'hff, r_src);
        chk(0, {c_on, c_sw, c_pecl});
        chk(0, cko);
        rd(cocr_pkg::REF_DLY_ADDR[0], 8'h10);
        rd(cocr_pkg::REF_EN_ADDR, 8'h00);
        $display("test reset done");
        // All ones first: reserved bits must read back zero
        for (int i = 0; i < 8; i++) begin
            {v, w} = (i == 0) ? 16'hffff : 16'($random(seed));
            xfer(1'b0, cocr_pkg::REF_DLY_ADDR[i], v);
            xfer(1'b0, cocr_pkg::REF_DRV_ADDR[i], w);
            rd(cocr_pkg::REF_DLY_ADDR[i], v & 8'h7f);
            rd(cocr_pkg::REF_DRV_ADDR[i], w & 8'hbc);
            chk({v[0], v[6:5], v[3:1], v[4]},
                {r_fin[i], r_crs[i], r_src[i]});
            chk(w[7:2] & 6'h2f,
                {r_pd[i], 1'b0, r_bias[i], r_pecl[i], r_sw[i]});
        end
        $display("test reference settings done");
        for (int i = 0; i < 10; i++) begin
            w = (i == 0) ? 8'hff : 8'($random(seed));
            xfer(1'b0, cocr_pkg::CLK_DRV_ADDR[i], w);
            rd(cocr_pkg::CLK_DRV_ADDR[i], w & 8'h9c);
            chk({w[7], w[4:2]}, {c_pd[i], c_pecl[i], c_sw[i]});
        end
        $display("test clock settings done");
        // Last pass turns every output off again
        for (int k = 0; k < 3; k++) begin
            {v, w} = (k == 2) ? 16'h0 : 16'($random(seed));
            xfer(1'b0, cocr_pkg::REF_EN_ADDR, v);
            xfer(1'b0, cocr_pkg::CLK_EN_HI_ADDR, w);
            xfer(1'b0, cocr_pkg::CLK_EN_LO_ADDR, v);
            rd(cocr_pkg::REF_EN_ADDR, v);
            rd(cocr_pkg::CLK_EN_HI_ADDR, w);
            rd(cocr_pkg::CLK_EN_LO_ADDR, v & 8'h03);
            chk(rev8(v), r_on);
            chk({v[1:0], rev8(w)}, c_on);
        end
        chk(0, {cko, rfo});
        $display("test enables done");
        xfer(1'b0, 7'h00, 8'h5a);
        rd(7'h00, 8'h00);
        xfer(1'b0, cocr_pkg::REF_DLY_ADDR[0], 8'h00, 10);
        rd(cocr_pkg::REF_DLY_ADDR[0], 8'h7f);
        $display("test refused frames done");
        do_reset();
        rd(cocr_pkg::REF_DLY_ADDR[7], 8'h10);
        chk(8'hff, r_src);
        chk(0, exp_q.size());
        $display("test second reset done");
        end_of_test();
    end
endmodule : cocr_regs_tb_top
